// ### design/stl_pkg.sv
// Package: constants and carrier types for the self-test error lockout
package stl_pkg;

    // Number of failure sources feeding the lockout
    localparam int unsigned FAIL_SRC_COUNT = 6;

    // Fault code width and values loaded into the fault information register
    localparam int unsigned FAULT_CODE_W    = 8;
    localparam logic [7:0]  FAULT_NONE      = 8'h00;
    localparam logic [7:0]  FAULT_BOOT      = 8'h01;
    localparam logic [7:0]  FAULT_INTEGRITY = 8'h02;
    localparam logic [7:0]  FAULT_COND     = 8'h03;
    localparam logic [7:0]  FAULT_HEALTH    = 8'h04;
    localparam logic [7:0]  FAULT_RING_OSC  = 8'h05;
    localparam logic [7:0]  FAULT_SELFTEST  = 8'h06;

    // Zeroize sweep: SRAM depth and address width
    localparam int unsigned SRAM_DEPTH  = 64;
    localparam int unsigned SRAM_ADDR_W = 6;
    localparam int unsigned SRAM_DATA_W = 32;

    // Restart delay after zeroize before operation is allowed, in cycles
    localparam logic [7:0] RESTART_CYCLES = 8'h10;

    // Approved-mode value shown in status
    localparam logic APPROVED_MODE_ON = 1'b1;

    // Failure inputs, one bit per cause
    typedef struct packed {
        logic boot_fail;       // Start-up self-test or boot chain integrity failure
        logic integrity_fail;  // Integrity test failure
        logic cond_fail;       // Conditional known-answer or pairwise test failure
        logic health_fail;     // Entropy health test failure
        logic ring_osc_fail;   // Ring-oscillator entropy source failure
        logic selftest_fail;   // On-demand self-test failure
    } stl_fail_type;

    // Status report word
    typedef struct packed {
        logic [31:0] hardware_build_version;
        logic [31:0] firmware_version;
        logic [31:0] supervisor_version;
        logic        approved_mode;
    } stl_status_type;

    // Lockout states
    typedef enum logic [2:0] {
        ST_ZEROIZE = 3'b000,
        ST_RESTART = 3'b001,
        ST_OPER    = 3'b010,
        ST_ERROR   = 3'b011
    } stl_state_type;

endpackage

// ### design/stl_lockout.sv
// Self-test error lockout: error state, gating, zeroize and restart sequencing
//
// Notes on behaviour
// - Any listed self-test failure in restart or operation enters error state
// - Error state blocks crypto, output; status only
// - Error entry raises halt and loads fault info
// - Only hard or power-on reset clears error
// - Either reset zeroizes all SRAM dynamic assets
// - Operation resumes only via full restart sequence
// - Status gives versions and approved-mode flag
// - Boot test failure stops boot, enters error
`timescale 1ns/1ps

module stl_lockout
    import stl_pkg::*;
#(
    parameter logic [31:0] HW_BUILD_VERSION = 32'h0000_0001, // Arbitrary value
    parameter logic [31:0] FW_VERSION       = 32'h0000_0001, // Arbitrary value
    parameter logic [31:0] SUP_VERSION      = 32'h0000_0001  // Arbitrary value
) (
    input  wire logic                    mclk,
    input  wire logic                    hard_reset_n,
    input  wire logic                    power_on_reset_n,
    input  wire stl_pkg::stl_fail_type   fail_in,
    input  wire logic                    boot_done,
    input  wire logic                    crypto_req,
    input  wire logic                    data_out_req,
    input  wire logic                    status_req,
    output logic                         halt_indicator,
    output logic [7:0]                   internal_fault_info,
    output logic                         operational,
    output logic                         crypto_grant,
    output logic                         data_out_grant,
    output logic                         status_valid,
    output stl_pkg::stl_status_type      status_out,
    output logic                         sram_we,
    output logic [5:0]                   sram_addr,
    output logic [31:0]                  sram_wdata
);
    import stl_pkg::*;

    // The sweep port is six address bits wide; a larger SRAM would be left half wiped
    if (SRAM_ADDR_W != 6 || SRAM_DEPTH < 2 || SRAM_DEPTH > 64 || SRAM_DATA_W != 32) begin : g_bad
        $error("zeroize sweep cannot serve this SRAM size");
    end

    // Combined reset: either documented reset clears the lockout
    logic reset_n;                  // Either reset asserted pulls this low
    assign reset_n = hard_reset_n & power_on_reset_n;

    // Failure inputs come from other logic on mclk, so no synchroniser
    stl_state_type   state_reg;     // Lockout state
    stl_state_type   state_next;    // Next lockout state
    logic [5:0]      zaddr_reg;     // Zeroize sweep address
    logic [7:0]      rcnt_reg;      // Restart delay count
    logic            any_fail;      // Any cause present
    logic [7:0]      fault_code;    // Code of the highest-priority cause

    // Priority encode the failure causes; boot failures rank first
    always_comb begin
        any_fail   = |fail_in;
        fault_code = FAULT_NONE;
        if (fail_in.boot_fail) begin
            fault_code = FAULT_BOOT;
        end else if (fail_in.integrity_fail) begin
            fault_code = FAULT_INTEGRITY;
        end else if (fail_in.cond_fail) begin
            fault_code = FAULT_COND;
        end else if (fail_in.health_fail) begin
            fault_code = FAULT_HEALTH;
        end else if (fail_in.ring_osc_fail) begin
            fault_code = FAULT_RING_OSC;
        end else if (fail_in.selftest_fail) begin
            fault_code = FAULT_SELFTEST;
        end
    end

    // Next state: zeroize, then restart, then operate; error is absorbing
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_ZEROIZE: begin
                if (zaddr_reg == 6'(SRAM_DEPTH - 1)) begin
                    state_next = ST_RESTART;
                end
            end
            ST_RESTART: begin
                // Boot failure stops the sequence before operation starts
                if (any_fail) begin
                    state_next = ST_ERROR;
                end else if (rcnt_reg >= RESTART_CYCLES && boot_done) begin
                    state_next = ST_OPER;
                end
            end
            ST_OPER: begin
                if (any_fail) begin
                    state_next = ST_ERROR;
                end
            end
            ST_ERROR: begin
                // No input leaves here; only reset does
                state_next = ST_ERROR;
            end
            default: begin
                state_next = ST_ERROR;       // Corrupted state fails safe
            end
        endcase
    end

    // State register; reset always begins with zeroize
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= ST_ZEROIZE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Zeroize sweep over every SRAM word
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            zaddr_reg  <= 6'h00;
            sram_we    <= 1'b0;
            sram_addr  <= 6'h00;
            sram_wdata <= 32'h0000_0000;
        end else begin
            sram_wdata <= 32'h0000_0000;
            sram_we    <= (state_reg == ST_ZEROIZE);
            sram_addr  <= zaddr_reg;
            if (state_reg == ST_ZEROIZE && zaddr_reg != 6'(SRAM_DEPTH - 1)) begin
                zaddr_reg <= zaddr_reg + 6'h01;
            end
        end
    end

    // Restart delay counter, running only in the restart state
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rcnt_reg <= 8'h00;
        end else if (state_reg == ST_RESTART && rcnt_reg < RESTART_CYCLES) begin
            rcnt_reg <= rcnt_reg + 8'h01;
        end
    end

    // Halt and fault info: loaded on error entry, held until reset
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            halt_indicator      <= 1'b0;
            internal_fault_info <= FAULT_NONE;
        end else if (state_reg != ST_ERROR && state_next == ST_ERROR) begin
            halt_indicator      <= 1'b1;
            // Corrupt-state entry has no cause; still report nonzero
            internal_fault_info <= (fault_code == FAULT_NONE) ? FAULT_SELFTEST : fault_code;
        end
    end

    // Grants: crypto and data output only when operating
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            operational    <= 1'b0;
            crypto_grant   <= 1'b0;
            data_out_grant <= 1'b0;
        end else begin
            operational    <= (state_next == ST_OPER);
            crypto_grant   <= (state_next == ST_OPER) && crypto_req;
            data_out_grant <= (state_next == ST_OPER) && data_out_req;
        end
    end

    // Status service stays available in every state, error included
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            status_valid <= 1'b0;
            status_out   <= '0;
        end else begin
            status_valid <= status_req;
            if (status_req) begin
                status_out.hardware_build_version <= HW_BUILD_VERSION;
                status_out.firmware_version       <= FW_VERSION;
                status_out.supervisor_version     <= SUP_VERSION;
                status_out.approved_mode          <= APPROVED_MODE_ON;
            end
        end
    end

    // Checks
    halt_on_error_a: assert property (@(posedge mclk) disable iff (!reset_n)
        (state_reg != ST_ERROR && state_next == ST_ERROR) |=> halt_indicator
        && internal_fault_info != FAULT_NONE)
        else $error("halt or fault info missing on error entry");
    fail_enters_error_a: assert property (@(posedge mclk) disable iff (!reset_n)
        (state_reg == ST_OPER && any_fail) |=> state_reg == ST_ERROR)
        else $error("failure did not enter error state");
    error_blocks_crypto_a: assert property (@(posedge mclk) disable iff (!reset_n)
        state_reg == ST_ERROR |-> ##1 (!crypto_grant && !data_out_grant))
        else $error("grant while in error state");
    error_sticky_a: assert property (@(posedge mclk) disable iff (!reset_n)
        state_reg == ST_ERROR |=> state_reg == ST_ERROR && halt_indicator)
        else $error("error state left without reset");
    zeroize_write_a: assert property (@(posedge mclk) disable iff (!reset_n)
        state_reg == ST_ZEROIZE |=> sram_we && sram_wdata == 32'h0000_0000)
        else $error("zeroize write missing");
    oper_via_restart_a: assert property (@(posedge mclk) disable iff (!reset_n)
        $rose(state_reg == ST_OPER) |-> $past(state_reg) == ST_RESTART)
        else $error("operation entered without restart");
    status_answer_a: assert property (@(posedge mclk) disable iff (!reset_n)
        status_req |=> status_valid && status_out.approved_mode == APPROVED_MODE_ON)
        else $error("status not answered");
    boot_fail_halt_a: assert property (@(posedge mclk) disable iff (!reset_n)
        (state_reg == ST_RESTART && fail_in.boot_fail) |=> ##[0:1]
        (state_reg == ST_ERROR && internal_fault_info == FAULT_BOOT))
        else $error("boot failure not reported");
    grant_needs_oper_a: assert property (@(posedge mclk) disable iff (!reset_n)
        (crypto_grant || data_out_grant) |-> state_reg == ST_OPER)
        else $error("grant outside operating state");

    cov_reach_oper_c:  cover property (@(posedge mclk) disable iff (!reset_n)
        state_reg == ST_OPER);
    cov_oper_error_c:  cover property (@(posedge mclk) disable iff (!reset_n)
        state_reg == ST_OPER ##1 state_reg == ST_ERROR);
    cov_boot_error_c:  cover property (@(posedge mclk) disable iff (!reset_n)
        state_reg == ST_RESTART ##1 state_reg == ST_ERROR);
    cov_err_status_c:  cover property (@(posedge mclk) disable iff (!reset_n)
        state_reg == ST_ERROR && status_valid);
    cov_rst_oper_c:    cover property (@(posedge mclk) disable iff (!reset_n)
        state_reg == ST_RESTART ##1 state_reg == ST_OPER);

endmodule

// ### verification/stl_host_model.sv
// Host-side model: firmware reports boot completion after a reset
`timescale 1ns/1ps
module stl_host_model (
    input  wire logic       mclk,
    input  wire logic       hard_reset_n,
    input  wire logic       power_on_reset_n,
    input  wire logic [7:0] boot_delay,
    output logic            boot_done
);
    wire logic       rst_n = hard_reset_n & power_on_reset_n; // Either reset restarts boot
    logic      [7:0] cnt_reg;                                  // Cycles since reset release
    // Boot done rises after boot_delay cycles; zero gives a prompt host
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg   <= 8'h00;
            boot_done <= 1'b0;
        end else begin
            if (cnt_reg != 8'hff) begin
                cnt_reg <= cnt_reg + 8'h01;
            end
            boot_done <= (cnt_reg >= boot_delay);
        end
    end
endmodule

// ### verification/tb_top.sv
// Testbench: lockout entry, gating, zeroize sweep and restart
`timescale 1ns/1ps
module tb_top;
    import stl_pkg::*;
    logic mclk = 1'b0, hard_reset_n, power_on_reset_n, boot_done;
    logic crypto_req, data_out_req, status_req, halt_indicator, operational;
    logic crypto_grant, data_out_grant, status_valid, sram_we;
    logic [7:0] internal_fault_info, boot_delay, code;
    logic [5:0] sram_addr, f;
    logic [31:0] sram_wdata, seed = 32'ha3b6;
    stl_fail_type fail_in;
    stl_status_type status_out;
    int miscompares = 0, compares = 0, cycles = 0, n;
    // Arbitrary version values, distinct so a swapped field shows
    localparam stl_status_type EXP_ST = {32'h0000_0a11, 32'h0000_0b22,
                                         32'h0000_0c33, APPROVED_MODE_ON};
    stl_lockout #(.HW_BUILD_VERSION(32'h0000_0a11), .FW_VERSION(32'h0000_0b22),
                  .SUP_VERSION(32'h0000_0c33)) u_stl_lockout (.mclk(mclk),
        .hard_reset_n(hard_reset_n), .power_on_reset_n(power_on_reset_n),
        .fail_in(fail_in), .boot_done(boot_done), .crypto_req(crypto_req),
        .data_out_req(data_out_req), .status_req(status_req),
        .halt_indicator(halt_indicator), .internal_fault_info(internal_fault_info),
        .operational(operational), .crypto_grant(crypto_grant),
        .data_out_grant(data_out_grant), .status_valid(status_valid),
        .status_out(status_out), .sram_we(sram_we), .sram_addr(sram_addr),
        .sram_wdata(sram_wdata));
    stl_host_model u_stl_host_model (.mclk(mclk), .hard_reset_n(hard_reset_n),
        .power_on_reset_n(power_on_reset_n), .boot_delay(boot_delay),
        .boot_done(boot_done));
    always #5 mclk = ~mclk;
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // Highest-priority failure decides the code
    function automatic logic [7:0] exp_code(input logic [5:0] v);
        for (int i = 5; i >= 0; i--) if (v[i]) return 8'(6 - i);
        return FAULT_NONE;
    endfunction
    task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Random requests; err also throws stray failures that must be ignored
    task automatic traffic(input bit err);
        logic [2:0] p, r;
        p = 3'b000;
        repeat (30) begin
            @(posedge mclk);
            seed = lfsr(seed);
            r = seed[2:0];
            {crypto_req, data_out_req, status_req} <= r;
            if (err) fail_in <= stl_fail_type'(seed[8:3]);
            @(negedge mclk);
            chk(crypto_grant, p[2] & !err);
            chk(data_out_grant, p[1] & !err);
            chk(status_valid, p[0]);
            if (p[0]) chk(status_out, EXP_ST);
            chk({halt_indicator, operational}, {err, !err});
            if (err) chk(internal_fault_info, code);
            p = r;
        end
    endtask
    always @(posedge mclk) begin
        cycles++;
        if (cycles > 5000) begin
            miscompares++;
            final_report();
        end
    end
    initial begin
        {hard_reset_n, power_on_reset_n, crypto_req, data_out_req, status_req} = '0;
        fail_in = '0;
        boot_delay = 8'h00;
        repeat (4) @(posedge mclk);
        for (int t = 0; t < 7; t++) begin
            boot_delay = t[0] ? 8'h96 : 8'h00; // Slow and prompt host
            @(posedge mclk);
            {hard_reset_n, power_on_reset_n} <= 2'b11;
            @(negedge mclk);
            for (int k = 0; k < 64; k++) begin
                @(negedge mclk);
                chk({sram_we, sram_addr, sram_wdata, operational}, {1'b1, 6'(k), 33'h0});
            end
            if (t == 6) begin
                @(posedge mclk);
                fail_in <= stl_fail_type'(6'h20); // Boot failure during restart
                code = FAULT_BOOT;
            end else begin
                for (n = 0; operational !== 1'b1 && n < 400; n++) @(negedge mclk);
                chk(operational, 1'b1);
                chk(n >= (t[0] ? 86 : RESTART_CYCLES), 1'b1);
                chk(sram_we, 1'b0);
                traffic(1'b0);
                @(posedge mclk);
                seed = lfsr(seed);
                f = (6'h20 >> t) | (seed[5:0] & ((6'h20 >> t) - 6'h01));
                {crypto_req, data_out_req, status_req} <= 3'b000;
                fail_in <= stl_fail_type'(f);
                code = exp_code(f);
            end
            @(posedge mclk);
            fail_in <= '0;
            @(negedge mclk);
            chk({halt_indicator, internal_fault_info, operational}, {1'b1, code, 1'b0});
            traffic(1'b1);
            @(posedge mclk);
            if (t[0]) hard_reset_n <= 1'b0;
            else power_on_reset_n <= 1'b0;
            {crypto_req, data_out_req, status_req} <= 3'b000;
            fail_in <= '0;
            @(negedge mclk);
            chk({halt_indicator, internal_fault_info, operational}, 10'h0);
            chk({crypto_grant, data_out_grant, status_valid, sram_we}, 4'h0);
            repeat (2) @(posedge mclk);
        end
        final_report();
    end
endmodule
